/* src/rmis_top.v */
// Register file and source routing for the remappable inputs.
`timescale 1ns/1ps
`include "rmis_defs.vh"

module rmis_top #(
  parameter CAN_PRESENT = 1
) (
  input  wire                       clk_in,
  input  wire                       sys_rst_in,
  input  wire [`RMIS_ADDR_W-1:0]    reg_addr_in,
  input  wire [`RMIS_DATA_W-1:0]    reg_wdata_in,
  input  wire                       reg_wr_in,
  input  wire                       reg_rd_in,
  output wire [`RMIS_DATA_W-1:0]    reg_rdata_out,
  input  wire                       comparator1_output_in,
  input  wire                       comparator2_output_in,
  input  wire                       comparator3_output_in,
  input  wire                       comparator4_output_in,
  input  wire                       comparator5_output_in,
  input  wire                       trigger_generator_out30_in,
  input  wire                       trigger_generator_out31_in,
  input  wire                       enc1_filtered_index_in,
  input  wire                       enc1_filtered_home_in,
  input  wire                       enc2_filtered_index_in,
  input  wire                       enc2_filtered_home_in,
  input  wire [`RMIS_NUM_SRC-1:0]   remap_pin_in,
  input  wire [`RMIS_NUM_SRC-1:0]   pin_analog_in,
  output wire [`RMIS_NUM_SRC-1:0]   pin_claim_out,
  output wire                       ext_int1_out,
  output wire                       ext_int2_out,
  output wire                       timer2_clock_out,
  output wire                       capture1_out,
  output wire                       capture2_out,
  output wire                       capture3_out,
  output wire                       capture4_out,
  output wire                       capture5_out,
  output wire                       capture6_out,
  output wire                       capture7_out,
  output wire                       capture8_out,
  output wire                       compare_fault_a_out,
  output wire                       pwm_fault_one_out,
  output wire                       pwm_fault_two_out,
  output wire                       enc1_phase_a_out,
  output wire                       enc1_phase_b_out,
  output wire                       enc1_index_out,
  output wire                       enc1_home_out,
  output wire                       enc2_phase_a_out,
  output wire                       enc2_phase_b_out,
  output wire                       enc2_index_out,
  output wire                       enc2_home_out,
  output wire                       serial1_receive_out,
  output wire                       serial2_receive_out,
  output wire                       spi2_data_out,
  output wire                       spi2_clock_out,
  output wire                       spi2_select_out,
  output wire                       codec_serial_in_out,
  output wire                       codec_bit_clock_out,
  output wire                       codec_frame_sync_out,
  output wire                       can1_receive_out,
  output wire                       can2_receive_out,
  output wire                       serial3_receive_out,
  output wire                       serial3_cts_out,
  output wire                       serial4_receive_out,
  output wire                       serial4_cts_out,
  output wire                       spi3_data_out,
  output wire                       spi3_clock_out,
  output wire                       spi3_select_out,
  output wire                       pwm_sync_out,
  output wire                       deadtime_comp1_out,
  output wire                       deadtime_comp2_out,
  output wire                       deadtime_comp3_out,
  output wire                       deadtime_comp4_out,
  output wire                       deadtime_comp5_out,
  output wire                       deadtime_comp6_out
);

  // ==========================================================
  // Field indices, in register order, low slot before high
  localparam F_INT1  = 0;
  localparam F_INT2  = 1;
  localparam F_T2CK  = 2;
  localparam F_CAP1  = 3;
  localparam F_CAP2  = 4;
  localparam F_CAP3  = 5;
  localparam F_CAP4  = 6;
  localparam F_CAP5  = 7;
  localparam F_CAP6  = 8;
  localparam F_CAP7  = 9;
  localparam F_CAP8  = 10;
  localparam F_OCFLT = 11;
  localparam F_PFLT1 = 12;
  localparam F_PFLT2 = 13;
  localparam F_E1PA  = 14;
  localparam F_E1PB  = 15;
  localparam F_E1IX  = 16;
  localparam F_E1HM  = 17;
  localparam F_E2PA  = 18;
  localparam F_E2PB  = 19;
  localparam F_E2IX  = 20;
  localparam F_E2HM  = 21;
  localparam F_S1RX  = 22;
  localparam F_S2RX  = 23;
  localparam F_P2DAT = 24;
  localparam F_P2CLK = 25;
  localparam F_P2SEL = 26;
  localparam F_CDAT  = 27;
  localparam F_CCLK  = 28;
  localparam F_CFRM  = 29;
  localparam F_CAN1  = 30;
  localparam F_CAN2  = 31;
  localparam F_S3RX  = 32;
  localparam F_S3CTS = 33;
  localparam F_S4RX  = 34;
  localparam F_S4CTS = 35;
  localparam F_P3DAT = 36;
  localparam F_P3CLK = 37;
  localparam F_P3SEL = 38;
  localparam F_SYNC  = 39;
  localparam F_DT1   = 40;
  localparam F_DT2   = 41;
  localparam F_DT3   = 42;
  localparam F_DT4   = 43;
  localparam F_DT5   = 44;
  localparam F_DT6   = 45;

  localparam [`RMIS_NUM_REGS-1:0] TWO_FIELD = `RMIS_TWO_FIELD;
  localparam NF = `RMIS_NUM_FIELDS;
  localparam SW = `RMIS_SEL_W;

  // ==========================================================
  // Field placement decode
  function [4:0] field_reg;
    input integer f;
    integer r;
    integer n;
    begin
      field_reg = 5'h00;
      n = 0;
      for (r = 0; r < `RMIS_NUM_REGS; r = r + 1) begin
        if (f >= n && f <= n + TWO_FIELD[r]) begin
          field_reg = r[4:0];
        end
        n = n + 1 + TWO_FIELD[r];
      end
    end
  endfunction

  function field_slot;
    input integer f;
    integer r;
    integer n;
    begin
      field_slot = 1'b0;
      n = 0;
      for (r = 0; r < `RMIS_NUM_REGS; r = r + 1) begin
        if (TWO_FIELD[r] && f == n + 1) begin
          field_slot = 1'b1;
        end
        n = n + 1 + TWO_FIELD[r];
      end
    end
  endfunction

  // Writable bits of a map register; reserved bits stay zero.
  function [`RMIS_DATA_W-1:0] wr_mask;
    input [`RMIS_ADDR_W-1:0] a;
    begin
      if (a == `RMIS_IN_MAP_CAN_RX && CAN_PRESENT == 0) begin
        wr_mask = 16'h0000;
      end else if (TWO_FIELD[a]) begin
        wr_mask = `RMIS_MASK_TWO;
      end else begin
        wr_mask = `RMIS_MASK_ONE;
      end
    end
  endfunction

  // ==========================================================
  // Input map register file
  // Only input maps live here; output maps are a separate block,
  // so an input choice never disturbs an output choice.
  reg  [`RMIS_DATA_W-1:0] map_q [0:`RMIS_NUM_REGS-1];
  reg  [`RMIS_DATA_W-1:0] rdata_q;
  reg  [`RMIS_NUM_SRC-1:0] claim_q;
  reg  [`RMIS_NUM_SRC-1:0] claim_d;
  wire [NF-1:0]           pin_sel;
  wire [NF*SW-1:0]        sel_flat;
  wire                    map_hit;
  integer                 i;
  integer                 j;

  assign map_hit = (reg_addr_in < `RMIS_NUM_REGS);

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (i = 0; i < `RMIS_NUM_REGS; i = i + 1) begin
        map_q[i] <= `RMIS_MAP_RESET;
      end
    end else if (reg_wr_in && map_hit) begin
      map_q[reg_addr_in] <= reg_wdata_in & wr_mask(reg_addr_in);
    end
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_in) begin
      if (map_hit) begin
        rdata_q <= map_q[reg_addr_in];
      end else begin
        case (reg_addr_in)
          `RMIS_STATUS_LO: begin
            rdata_q <= pin_sel[15:0];
          end
          `RMIS_STATUS_MID: begin
            rdata_q <= pin_sel[31:16];
          end
          `RMIS_STATUS_HI: begin
            rdata_q <= {2'h0, pin_sel[45:32]};
          end
          default: begin
            rdata_q <= 16'h0000;
          end
        endcase
      end
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ==========================================================
  // Source vector
  wire [`RMIS_NUM_VIRT-1:0] virt_src;
  wire [`RMIS_NUM_SRC-1:0]  raw_src;
  wire [`RMIS_NUM_SRC-1:0]  src;

  assign virt_src = {
    3'h0,
    comparator5_output_in,
    enc2_filtered_home_in,
    enc2_filtered_index_in,
    enc1_filtered_home_in,
    enc1_filtered_index_in,
    trigger_generator_out31_in,
    trigger_generator_out30_in,
    1'b0,
    comparator4_output_in,
    comparator3_output_in,
    comparator2_output_in,
    comparator1_output_in,
    1'b0
  };

  // An analog pin reads low to every remapped input.
  assign raw_src = {remap_pin_in[`RMIS_NUM_SRC-1:`RMIS_NUM_VIRT] &
                    ~pin_analog_in[`RMIS_NUM_SRC-1:`RMIS_NUM_VIRT],
                    virt_src};

  // Codes out of range or unimplemented deliver a constant low,
  // which is also the safe answer to a careless write.
  assign src = raw_src & `RMIS_IMPL_MASK;

  // ==========================================================
  // One selector per peripheral input
  genvar f;
  generate
    for (f = 0; f < NF; f = f + 1) begin : g_fld
      localparam [4:0] R = field_reg(f);
      localparam       S = field_slot(f);
      wire [SW-1:0]    sel;
      if (S) begin : g_hi
        assign sel = map_q[R][`RMIS_HI_MSB:`RMIS_HI_LSB];
      end else begin : g_lo
        assign sel = map_q[R][`RMIS_LO_MSB:`RMIS_LO_LSB];
      end
      assign sel_flat[f*SW +: SW] = sel;
      rmis_field_mux u_mux (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .sel_in     (sel),
        .src_in     (src),
        .drive_out  (pin_sel[f])
      );
    end
  endgenerate

  // ==========================================================
  // Pin claims
  // A claimed pin is handed to the remapped peripheral ahead of
  // port and other digital use; analog pins are never claimed.
  always @* begin
    claim_d = {`RMIS_NUM_SRC{1'b0}};
    for (j = 0; j < NF; j = j + 1) begin
      claim_d[sel_flat[j*SW +: SW]] = 1'b1;
    end
    claim_d = claim_d & `RMIS_IMPL_MASK & `RMIS_PIN_MASK &
              ~pin_analog_in;
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      claim_q <= {`RMIS_NUM_SRC{1'b0}};
    end else begin
      claim_q <= claim_d;
    end
  end

  assign pin_claim_out = claim_q;

  // ==========================================================
  // Peripheral inputs
  assign ext_int1_out        = pin_sel[F_INT1];
  assign ext_int2_out        = pin_sel[F_INT2];
  assign timer2_clock_out    = pin_sel[F_T2CK];
  assign capture1_out        = pin_sel[F_CAP1];
  assign capture2_out        = pin_sel[F_CAP2];
  assign capture3_out        = pin_sel[F_CAP3];
  assign capture4_out        = pin_sel[F_CAP4];
  assign capture5_out        = pin_sel[F_CAP5];
  assign capture6_out        = pin_sel[F_CAP6];
  assign capture7_out        = pin_sel[F_CAP7];
  assign capture8_out        = pin_sel[F_CAP8];
  assign compare_fault_a_out = pin_sel[F_OCFLT];
  assign pwm_fault_one_out   = pin_sel[F_PFLT1];
  assign pwm_fault_two_out   = pin_sel[F_PFLT2];
  assign enc1_phase_a_out    = pin_sel[F_E1PA];
  assign enc1_phase_b_out    = pin_sel[F_E1PB];
  assign enc1_index_out      = pin_sel[F_E1IX];
  assign enc1_home_out       = pin_sel[F_E1HM];
  assign enc2_phase_a_out    = pin_sel[F_E2PA];
  assign enc2_phase_b_out    = pin_sel[F_E2PB];
  assign enc2_index_out      = pin_sel[F_E2IX];
  assign enc2_home_out       = pin_sel[F_E2HM];
  assign serial1_receive_out = pin_sel[F_S1RX];
  assign serial2_receive_out = pin_sel[F_S2RX];
  assign spi2_data_out       = pin_sel[F_P2DAT];
  assign spi2_clock_out      = pin_sel[F_P2CLK];
  assign spi2_select_out     = pin_sel[F_P2SEL];
  assign codec_serial_in_out  = pin_sel[F_CDAT];
  assign codec_bit_clock_out  = pin_sel[F_CCLK];
  assign codec_frame_sync_out = pin_sel[F_CFRM];
  // On a variant without CAN the field is held at zero, so these
  // stay low whatever software attempts.
  assign can1_receive_out    = pin_sel[F_CAN1];
  assign can2_receive_out    = pin_sel[F_CAN2];
  assign serial3_receive_out = pin_sel[F_S3RX];
  assign serial3_cts_out     = pin_sel[F_S3CTS];
  assign serial4_receive_out = pin_sel[F_S4RX];
  assign serial4_cts_out     = pin_sel[F_S4CTS];
  assign spi3_data_out       = pin_sel[F_P3DAT];
  assign spi3_clock_out      = pin_sel[F_P3CLK];
  assign spi3_select_out     = pin_sel[F_P3SEL];
  assign pwm_sync_out        = pin_sel[F_SYNC];
  assign deadtime_comp1_out  = pin_sel[F_DT1];
  assign deadtime_comp2_out  = pin_sel[F_DT2];
  assign deadtime_comp3_out  = pin_sel[F_DT3];
  assign deadtime_comp4_out  = pin_sel[F_DT4];
  assign deadtime_comp5_out  = pin_sel[F_DT5];
  assign deadtime_comp6_out  = pin_sel[F_DT6];

endmodule

/* shared/rmis_defs.vh */
// Constants for the remappable input selector block.
// Overview of operation
// - Input maps kept apart from output maps
// - Each peripheral input owns one selector field
// - Seven-bit fields, one or two per map register
// - Value n of 16 and up routes remappable pin n
// - Comparator and trigger outputs are virtual sources
// - Filtered encoder index/home are virtual sources
// - Value one on fault one selects comparator one
// - Compare fault and PWM fault fields exist
// - Codec data, clock and frame fields exist
// - CAN receive fields only on CAN variants
// - Unimplemented values deliver no source
// - No default pin; reset selects nothing
// - Remap beats digital but never analog function
`ifndef RMIS_DEFS_VH
`define RMIS_DEFS_VH

// ==========================================================
// Sizes
`define RMIS_ADDR_W      5
`define RMIS_DATA_W      16
`define RMIS_SEL_W       7
`define RMIS_NUM_REGS    29
`define RMIS_NUM_FIELDS  46
`define RMIS_NUM_SRC     128
`define RMIS_NUM_VIRT    16

// ==========================================================
// Field positions inside a map register
`define RMIS_LO_MSB      6
`define RMIS_LO_LSB      0
`define RMIS_HI_MSB      14
`define RMIS_HI_LSB      8
`define RMIS_MASK_TWO    16'h7F7F
`define RMIS_MASK_ONE    16'h007F
`define RMIS_MAP_RESET   16'h0000
`define RMIS_TWO_FIELD   29'h0C7A9F78

// ==========================================================
// Register indices
`define RMIS_IN_MAP_EXT_INT1          5'h00
`define RMIS_IN_MAP_EXT_INT2          5'h01
`define RMIS_IN_MAP_TIMER2_CLOCK      5'h02
`define RMIS_IN_MAP_CAPTURE_1_2       5'h03
`define RMIS_IN_MAP_CAPTURE_3_4       5'h04
`define RMIS_IN_MAP_CAPTURE_5_6       5'h05
`define RMIS_IN_MAP_CAPTURE_7_8       5'h06
`define RMIS_IN_MAP_COMPARE_FAULT     5'h07
`define RMIS_IN_MAP_PWM_FAULTS        5'h08
`define RMIS_IN_MAP_ENC1_PHASES       5'h09
`define RMIS_IN_MAP_ENC1_INDEX_HOME   5'h0A
`define RMIS_IN_MAP_ENC2_PHASES       5'h0B
`define RMIS_IN_MAP_ENC2_INDEX_HOME   5'h0C
`define RMIS_IN_MAP_SERIAL1_RX        5'h0D
`define RMIS_IN_MAP_SERIAL2_RX        5'h0E
`define RMIS_IN_MAP_SPI2_DATA_CLOCK   5'h0F
`define RMIS_IN_MAP_SPI2_SELECT       5'h10
`define RMIS_IN_MAP_CODEC_DATA_CLOCK  5'h11
`define RMIS_IN_MAP_CODEC_FRAME       5'h12
`define RMIS_IN_MAP_CAN_RX            5'h13
`define RMIS_IN_MAP_SERIAL3_RX_CTS    5'h14
`define RMIS_IN_MAP_SERIAL4_RX_CTS    5'h15
`define RMIS_IN_MAP_SPI3_DATA_CLOCK   5'h16
`define RMIS_IN_MAP_SPI3_SELECT       5'h17
`define RMIS_IN_MAP_PWM_SYNC          5'h18
`define RMIS_IN_MAP_DEADTIME_COMP1    5'h19
`define RMIS_IN_MAP_DEADTIME_COMP2_3  5'h1A
`define RMIS_IN_MAP_DEADTIME_COMP4_5  5'h1B
`define RMIS_IN_MAP_DEADTIME_COMP6    5'h1C
`define RMIS_STATUS_LO                5'h1D
`define RMIS_STATUS_MID               5'h1E
`define RMIS_STATUS_HI                5'h1F

// ==========================================================
// Selector encoding
`define RMIS_SEL_VSS     7'h00
`define RMIS_SEL_CMP1    7'h01
`define RMIS_FIRST_PIN   7'h10
`define RMIS_IMPL_MASK   128'h00000000_00033160_B7FFF1FF_1B1F1FDF
`define RMIS_PIN_MASK    128'hFFFFFFFF_FFFFFFFF_FFFFFFFF_FFFF0000

`endif

/* src/rmis_field_mux.v */
// One selector field driving one peripheral input.
`timescale 1ns/1ps
`include "rmis_defs.vh"

module rmis_field_mux (
  input  wire                       clk_in,
  input  wire                       sys_rst_in,
  input  wire [`RMIS_SEL_W-1:0]     sel_in,
  input  wire [`RMIS_NUM_SRC-1:0]   src_in,
  output wire                       drive_out
);

  reg drive_q;

  // ==========================================================
  // Source pick
  // The source vector arrives already masked, so unimplemented
  // codes yield a constant low here.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= src_in[sel_in];
    end
  end

  assign drive_out = drive_q;

endmodule

/* dv/rmis_top_sva.sv */
// Assertion checker bound to the remappable input selector top.
`timescale 1ns/1ps
`include "rmis_defs.vh"

module rmis_top_sva #(
  parameter CAN_PRESENT = 1
) (
  input wire         clk_in,
  input wire         sys_rst_in,
  input wire [4:0]   reg_addr_in,
  input wire [15:0]  reg_wdata_in,
  input wire         reg_wr_in,
  input wire         reg_rd_in,
  input wire [15:0]  reg_rdata_out,
  input wire         comparator1_output_in,
  input wire         comparator2_output_in,
  input wire         comparator3_output_in,
  input wire         comparator4_output_in,
  input wire         comparator5_output_in,
  input wire         trigger_generator_out30_in,
  input wire         trigger_generator_out31_in,
  input wire         enc1_filtered_index_in,
  input wire         enc1_filtered_home_in,
  input wire         enc2_filtered_index_in,
  input wire         enc2_filtered_home_in,
  input wire [127:0] remap_pin_in,
  input wire [127:0] pin_analog_in,
  input wire [127:0] pin_claim_out,
  input wire         pwm_fault_one_out,
  input wire         pwm_fault_two_out
);
  // ==========================================================
  // Shadow of the fault selector register and the source vector
  localparam [127:0] impl_c = `RMIS_IMPL_MASK;
  reg  [15:0]  fmap_q;
  wire [127:0] src_w;
  wire [6:0]   sel1_w = fmap_q[6:0];
  wire         exp1_w = src_w[fmap_q[6:0]];
  wire         exp2_w = src_w[fmap_q[14:8]];
  wire         claim_w = sel1_w >= 7'h10 && impl_c[sel1_w] &&
                         !pin_analog_in[sel1_w];
  assign src_w = impl_c & ((remap_pin_in & ~pin_analog_in & `RMIS_PIN_MASK)
    | {115'h0, comparator5_output_in, enc2_filtered_home_in,
    enc2_filtered_index_in, enc1_filtered_home_in, enc1_filtered_index_in,
    trigger_generator_out31_in, trigger_generator_out30_in, 1'b0,
    comparator4_output_in, comparator3_output_in, comparator2_output_in,
    comparator1_output_in, 1'b0});
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      fmap_q <= 16'h0000;
    end else if (reg_wr_in && reg_addr_in == 5'h08) begin
      fmap_q <= reg_wdata_in & 16'h7F7F;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_map_readback: assert property (
    reg_rd_in && reg_addr_in == 5'h08 |=> reg_rdata_out == fmap_q)
    else $error("fault map read back wrong");
  a_fault1_route: assert property (
    !$past(sys_rst_in) |-> pwm_fault_one_out == $past(exp1_w))
    else $error("fault one not from its source");
  a_fault2_route: assert property (
    !$past(sys_rst_in) |-> pwm_fault_two_out == $past(exp2_w))
    else $error("fault two not from its source");
  a_cmp1_fault: assert property (
    reg_wr_in && reg_addr_in == 5'h08 && reg_wdata_in[6:0] == 7'h01 ##1
    !reg_wr_in && comparator1_output_in |=> pwm_fault_one_out)
    else $error("comparator one missed fault one");
  a_claim_pin: assert property (
    !$past(sys_rst_in) && $past(claim_w) |->
    pin_claim_out[$past(sel1_w)])
    else $error("selected pin not claimed");
  a_analog_free: assert property (
    !$past(sys_rst_in) |-> (pin_claim_out & $past(pin_analog_in)) == 128'h0)
    else $error("analog pin claimed");
  a_virtual_unclaimed: assert property (
    pin_claim_out[15:0] == 16'h0000)
    else $error("virtual code claimed a pin");
  a_unimpl_zero: assert property (
    !$past(sys_rst_in) && !impl_c[$past(sel1_w)] |-> !pwm_fault_one_out)
    else $error("unimplemented code gave a level");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst_in |=> !pwm_fault_one_out && pin_claim_out == 128'h0)
    else $error("outputs not quiet in reset");
  c_cmp1: cover property (reg_wr_in && reg_wdata_in[6:0] == 7'h01);
  c_claim: cover property (|pin_claim_out);
  c_read: cover property (reg_rd_in && reg_addr_in == 5'h08);
endmodule

bind rmis_top rmis_top_sva #(.CAN_PRESENT(CAN_PRESENT)) i_rmis_top_sva (.*);

/* dv/rmis_pin_model.sv */
// Model of the pins and internal sources that feed the selector.
`timescale 1ns/1ps
`include "rmis_defs.vh"

module rmis_pin_model (
  input  wire         clk_in,
  input  wire [127:0] level_in,
  input  wire [127:0] analog_in,
  output reg  [127:0] pin_out,
  output reg  [127:0] analog_out,
  output reg  [10:0]  virt_out
);
  reg tgl_q;
  initial begin
    tgl_q = 1'b0;
    pin_out = 128'h0;
    analog_out = 128'h0;
    virt_out = 11'h000;
  end
  // ==========================================================
  // Sources change just after the edge, like real pins
  always @(posedge clk_in) begin
    tgl_q <= ~tgl_q;
    // Analog pins and slots below pin 16 hold no digital level, so they
    // toggle to expose a design that routes them anyway.
    pin_out <= (level_in & ~analog_in & `RMIS_PIN_MASK) |
      ({128{tgl_q}} & (analog_in | ~(`RMIS_PIN_MASK)));
    analog_out <= analog_in;
    virt_out[10:4] <= {level_in[1], level_in[2], level_in[3], level_in[4],
      level_in[12], level_in[6], level_in[7]};
    virt_out[3:0] <= {level_in[8], level_in[9], level_in[10],
      level_in[11]};
  end
endmodule

/* dv/rmis_top_test.sv */
// Self-checking testbench for the remappable input selector.
`timescale 1ns/1ps
`include "rmis_defs.vh"

module rmis_top_test;
  localparam [127:0] impl_c = `RMIS_IMPL_MASK;
  localparam [28:0]  two_c  = `RMIS_TWO_FIELD;
  reg          clk_in;
  reg          sys_rst_in;
  reg  [4:0]   reg_addr_in;
  reg  [15:0]  reg_wdata_in;
  reg          reg_wr_in;
  reg          reg_rd_in;
  reg  [127:0] level_q;
  reg  [127:0] analog_q;
  wire [15:0]  reg_rdata_out;
  wire [127:0] remap_pin_in;
  wire [127:0] pin_analog_in;
  wire [127:0] pin_claim_out;
  wire [10:0]  virt_w;
  wire comparator1_output_in, comparator2_output_in, comparator3_output_in,
    comparator4_output_in, comparator5_output_in, trigger_generator_out30_in,
    trigger_generator_out31_in, enc1_filtered_index_in, enc1_filtered_home_in,
    enc2_filtered_index_in, enc2_filtered_home_in;
  wire ext_int1_out, ext_int2_out, timer2_clock_out, capture1_out,
    capture2_out, capture3_out, capture4_out, capture5_out, capture6_out,
    capture7_out, capture8_out, compare_fault_a_out, pwm_fault_one_out,
    pwm_fault_two_out, enc1_phase_a_out, enc1_phase_b_out, enc1_index_out,
    enc1_home_out, enc2_phase_a_out, enc2_phase_b_out, enc2_index_out,
    enc2_home_out, serial1_receive_out, serial2_receive_out, spi2_data_out,
    spi2_clock_out, spi2_select_out, codec_serial_in_out, codec_bit_clock_out,
    codec_frame_sync_out, can1_receive_out, can2_receive_out,
    serial3_receive_out, serial3_cts_out, serial4_receive_out,
    serial4_cts_out, spi3_data_out, spi3_clock_out, spi3_select_out,
    pwm_sync_out, deadtime_comp1_out, deadtime_comp2_out, deadtime_comp3_out,
    deadtime_comp4_out, deadtime_comp5_out, deadtime_comp6_out;
  integer num_errors = 0;
  integer total_checks = 0;
  integer cyc_q = 0;
  integer i;

  assign {comparator1_output_in, comparator2_output_in, comparator3_output_in,
    comparator4_output_in, comparator5_output_in, trigger_generator_out30_in,
    trigger_generator_out31_in, enc1_filtered_index_in, enc1_filtered_home_in,
    enc2_filtered_index_in, enc2_filtered_home_in} = virt_w;
  rmis_top #(.CAN_PRESENT(1)) i_rmis_top (.*);
  rmis_pin_model i_rmis_pin_model (.clk_in(clk_in), .level_in(level_q),
    .analog_in(analog_q), .pin_out(remap_pin_in),
    .analog_out(pin_analog_in), .virt_out(virt_w));

  // ==========================================================
  // Clock, watchdog and shared tasks
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Full run needs about 1570 cycles.
  always @(posedge clk_in) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 6000) begin
      num_errors = num_errors + 1;
      results;
    end
  end
  task results;
    begin
      if (num_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [127:0] exp, input [127:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [15:0] e);
    begin
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 chk("read data", e, reg_rdata_out);
    end
  endtask
  task drive(input [127:0] lv, input [127:0] an);
    begin
      @(posedge clk_in);
      level_q <= lv;
      analog_q <= an;
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    reg_addr_in = 5'h00;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    level_q = 128'h0;
    analog_q = 128'h0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (i = 0; i < 32; i = i + 1) rd(i[4:0], 16'h0000);
    drive({128{1'b1}}, 128'h0);
    for (i = 0; i < 29; i = i + 1) begin
      wr(i[4:0], 16'hFFFF);
      rd(i[4:0], two_c[i] ? 16'h7F7F : 16'h007F);
    end
    wr(5'h1D, 16'hFFFF);
    for (i = 29; i < 32; i = i + 1) rd(i[4:0], 16'h0000);
    for (i = 0; i < 29; i = i + 1) wr(i[4:0], 16'h0000);
    wr(5'h0A, 16'h2524);
    for (i = 0; i < 128; i = i + 1) begin
      drive(128'h1 << i, 128'h0);
      wr(5'h08, {9'h000, i[6:0]});
      settle;
      chk("fault1 high", i != 0 && impl_c[i], pwm_fault_one_out);
      drive(~(128'h1 << i), 128'h0);
      settle;
      chk("fault one low", 128'h0, pwm_fault_one_out);
    end
    drive({128{1'b1}}, 128'h1 << 48);
    wr(5'h08, 16'h3001);
    settle;
    chk("fault two analog", 128'h0, pwm_fault_two_out);
    chk("claim analog", 128'h0, pin_claim_out[48]);
    chk("fault one cmp", 128'h1, pwm_fault_one_out);
    drive({128{1'b1}}, 128'h0);
    settle;
    chk("fault two pin", 128'h1, pwm_fault_two_out);
    chk("claims", (128'h3 << 36) | (128'h1 << 48), pin_claim_out);
    wr(5'h07, 16'h0020);
    wr(5'h11, 16'h2120);
    wr(5'h12, 16'h0022);
    wr(5'h13, 16'h2423);
    wr(5'h1C, 16'h0022);
    drive((128'h1 << 32) | (128'h3 << 34), 128'h0);
    settle;
    chk("codec data", 128'h1, codec_serial_in_out);
    chk("codec clock", 128'h0, codec_bit_clock_out);
    chk("codec frame", 128'h1, codec_frame_sync_out);
    chk("can pair", 128'h1, {can2_receive_out, can1_receive_out});
    chk("compare fault", 128'h1, compare_fault_a_out);
    chk("deadtime six", 128'h1, deadtime_comp6_out);
    rd(5'h1D, 16'h0800);
    rd(5'h1E, 16'h6800);
    rd(5'h1F, 16'h2000);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    settle;
    chk("after reset", 128'h0, compare_fault_a_out);
    chk("reset deadtime", 128'h0, deadtime_comp6_out);
    rd(5'h07, 16'h0000);
    results;
  end
endmodule
